/* ebac_top.sv */
// Overview of operation
// - release bit 0 keeps release pins as ports; 1 permits bus release.
// - low bus control bit 5 reads 0; reserved bits written as software says.
// - low bus control bit 0 gates the external stall pin.
// - four-bit code enables that many upper address lines from 8; 1111 all.
// - enabled pins drive address regardless of direction; others are ports.
// - address code resets to 1101 in modes 4 and 5, 0000 in 6 and 7.
// - sixteen megabytes split into eight two-megabyte areas, controlled per area.
// - one active-low select per area 0 to 5, low during an external access to it.
// - each select pin drives only when its direction bit is output.
// - ROM-disabled mode: area 0 select direction output, others input.
// - ROM-enabled mode: all select directions input until software sets them.
// - width bit 0 selects 16-bit area, 1 selects 8-bit area.
// - 8-bit bus mode only if all areas narrow; burst ROM forces 16-bit.
// - state bit 0 gives 2-state no waits; 1 gives 3-state with waits.
// - 3-state areas get 0 to 3 program waits from their wait field.
// - burst ROM area 0 takes its state count from its state bit, like other areas.
// - after reset every area is basic 3-state; width depends on mode.
// - only area 0 may use burst ROM; other areas basic only.
// - RAM enable routes area 7 RAM range internally, else external.
// - a state is one clock; on-chip ROM and RAM take one state.
// - on-chip peripheral registers take two states.
// - after program waits, stall pin low adds waits until it rises.
module ebac_top
   import ebac_pkg::*;
#(
   parameter logic [23:0] ROM_SIZE = 24'h020000,
   parameter logic [23:0] RAM_BASE = 24'hffb000,
   parameter logic [23:0] IO_BASE  = 24'hffc000
) (
   input  wire logic                        clock,          // 50 MHz system clock
   input  wire logic                        reset_n,        // power-on reset
   input  wire logic [2:0]                  mode_in,        // operating mode strap, 4 to 7
   input  wire logic [ebac_pkg::REG_AW-1:0] reg_addr,       // register index
   input  wire logic [7:0]                  reg_wdata,      // register write data
   input  wire logic                        reg_wr,         // write strobe
   input  wire logic                        reg_rd,         // read strobe
   output logic [7:0]                       reg_rdata,      // read data, cycle after strobe
   input  wire ebac_pkg::ebac_req_t         req,            // bus master access request
   output logic                             req_ready,      // idle, request may be made
   output ebac_pkg::ebac_rsp_t              rsp,            // access done pulse and details
   input  wire logic                        stall_n_in,     // external wait pin, low stalls
   input  wire logic                        release_request_pin, // bus release request
   output logic                             release_permit, // release pins act as bus pins
   output logic                             release_grant,  // release request accepted
   output logic                             stall_pin_enable, // wait pin in bus use
   output logic                             bus16,          // 16-bit bus mode
   output logic [5:0]                       area_select_n,  // area chip selects
   output logic [5:0]                       area_select_oe, // chip select pin enables
   input  wire logic [15:0]                 port_dout,      // port data for A8..A23 pins
   output logic [15:0]                      addr_pin_out,   // A8..A23 pin level
   output logic [15:0]                      addr_pin_oe     // A8..A23 pin enables
);
   // refused at elaboration, so a bad map never reaches a run
   if (IO_BASE <= RAM_BASE || RAM_BASE[23:21] != 3'h7) begin : g_bad_map
      $error("ebac_top: on-chip ram and io ranges must sit in area 7, ram below io");
   end

   typedef enum {IDLE, BUSY} ebac_state_t;

   logic              rst_meta_q;
   logic              rst_sync_q;
   logic              init_q;
   logic [2:0]        mode_q;
   logic [7:0]        width_q;
   logic [7:0]        state_q;
   logic [7:0]        pw_high_q;
   logic [7:0]        pw_low_q;
   logic [7:0]        bc_high_q;
   logic [7:0]        bc_low_q;
   logic [3:0]        ae_q;
   logic [7:0]        sys_q;
   logic [5:0]        cs_dir_q;
   logic [15:0]       adir_q;
   ebac_state_t       fsm_q;
   logic [2:0]        cnt_q;
   logic              waitable_q;
   logic [23:0]       addr_q;
   logic [7:0]        rd_d;
   logic [4:0]        ae_lines;
   logic [15:0]       ae_mask;
   logic              rom_disabled;
   logic              ram_en;
   logic              burst0;

   // ---- reset release and mode capture ----
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // strap is caught on the first edge after release, never by the reset itself
   always_ff @(posedge clock or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         init_q <= 1'b0;
         mode_q <= 3'h7;
      end else if (!init_q) begin
         init_q <= 1'b1;
         mode_q <= mode_in;
      end
   end

   assign rom_disabled = ~mode_q[1];
   assign ram_en       = sys_q[SYS_RAM_EN];
   assign burst0       = bc_high_q[BCH_BURST];

   function automatic logic [4:0] ae_count(input logic [3:0] code);
      ae_count = (code == 4'hf) ? 5'd16 : {1'b0, code};
   endfunction

   function automatic logic [1:0] pwait(input logic [2:0] area,
                                        input logic [7:0] hi,
                                        input logic [7:0] lo);
      logic [15:0] all;
      all   = {hi, lo};
      pwait = all[{area, 1'b0} +: 2];
   endfunction

   assign ae_lines = ae_count(ae_q);
   always_comb begin
      for (int i = 0; i < NUM_UPPER; i++) begin
         ae_mask[i] = (5'(i) < ae_lines);
      end
   end

   // ---- register file ----
   always_ff @(posedge clock or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         width_q   <= RST_W_NARROW;
         state_q   <= RST_STATE;
         pw_high_q <= RST_PW;
         pw_low_q  <= RST_PW;
         bc_high_q <= RST_BC_HIGH;
         bc_low_q  <= RST_BC_LOW;
         ae_q      <= RST_AE_ROM;
         sys_q     <= RST_SYS_CTRL;
         cs_dir_q  <= RST_CS_ROM;
         adir_q    <= 16'h0000;
      end else if (!init_q) begin
         // mode-dependent reset values land once the strap is known
         width_q  <= (mode_in == MODE_WIDE) ? RST_W_WIDE : RST_W_NARROW;
         ae_q     <= mode_in[1] ? RST_AE_ROM : RST_AE_ROMLESS;
         cs_dir_q <= mode_in[1] ? RST_CS_ROM : RST_CS_ROMLESS;
      end else if (reg_wr) begin
         unique case (reg_addr)
            OFS_WIDTH:    width_q   <= reg_wdata;
            OFS_STATE:    state_q   <= reg_wdata;
            OFS_PW_HIGH:  pw_high_q <= reg_wdata;
            OFS_PW_LOW:   pw_low_q  <= reg_wdata;
            OFS_BC_HIGH:  bc_high_q <= reg_wdata;
            OFS_BC_LOW:   bc_low_q  <= reg_wdata & BCL_WMASK;
            OFS_PIN_FUNC: ae_q      <= reg_wdata[3:0];
            OFS_SYS_CTRL: sys_q     <= reg_wdata;
            OFS_CS_DIR:   cs_dir_q  <= reg_wdata[5:0];
            OFS_ADIR_LO:  adir_q[7:0]  <= reg_wdata;
            OFS_ADIR_HI:  adir_q[15:8] <= reg_wdata;
            default: ;
         endcase
      end
   end

   always_comb begin
      unique case (reg_addr)
         OFS_WIDTH:    rd_d = width_q;
         OFS_STATE:    rd_d = state_q;
         OFS_PW_HIGH:  rd_d = pw_high_q;
         OFS_PW_LOW:   rd_d = pw_low_q;
         OFS_BC_HIGH:  rd_d = bc_high_q;
         OFS_BC_LOW:   rd_d = bc_low_q & BCL_WMASK;
         OFS_PIN_FUNC: rd_d = {4'h0, ae_q};
         OFS_SYS_CTRL: rd_d = sys_q;
         OFS_CS_DIR:   rd_d = {2'b00, cs_dir_q};
         OFS_ADIR_LO:  rd_d = adir_q[7:0];
         OFS_ADIR_HI:  rd_d = adir_q[15:8];
         default:      rd_d = 8'h00;
      endcase
   end

   always_ff @(posedge clock or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_rd ? rd_d : 8'h00;
      end
   end

   // ---- static pin functions ----
   always_ff @(posedge clock or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         release_permit   <= 1'b0;
         release_grant    <= 1'b0;
         stall_pin_enable <= 1'b0;
         bus16            <= 1'b0;
      end else begin
         release_permit   <= bc_low_q[BCL_RELEASE];
         release_grant    <= bc_low_q[BCL_RELEASE] & release_request_pin;
         stall_pin_enable <= bc_low_q[BCL_STALL];
         bus16            <= ~(&width_q) | burst0;
      end
   end

   // ---- access sequencer ----
   logic [2:0]        acc_area;
   ebac_route_t       acc_route;
   logic [2:0]        acc_len;
   logic              acc_wide;
   logic              acc_wait;
   logic [2:0]        ext_len;

   always_comb begin
      acc_area = req.addr[ADDR_W-1:AREA_LSB];
      if (acc_area == 3'h0 && !rom_disabled && req.addr < ROM_SIZE) begin
         acc_route = ROUTE_ROM;
      end else if (acc_area == 3'h7 && req.addr >= IO_BASE) begin
         acc_route = ROUTE_IO;
      end else if (acc_area == 3'h7 && req.addr >= RAM_BASE && ram_en) begin
         acc_route = ROUTE_RAM;
      end else begin
         acc_route = ROUTE_EXT;
      end
      // burst ROM full access follows the area 0 state bit as well
      ext_len = state_q[acc_area] ? ST_LONG + 3'(pwait(acc_area, pw_high_q, pw_low_q))
                                  : ST_SHORT;
      unique case (acc_route)
         ROUTE_ROM, ROUTE_RAM: acc_len = ST_ONCHIP;
         ROUTE_IO:             acc_len = ST_PERIPH;
         ROUTE_EXT:            acc_len = ext_len;
      endcase
      acc_wide = (acc_route != ROUTE_EXT) ? 1'b1
               : (~width_q[acc_area] | (acc_area == 3'h0 && burst0));
      acc_wait = (acc_route == ROUTE_EXT) && state_q[acc_area];
   end

   always_ff @(posedge clock or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         fsm_q         <= IDLE;
         cnt_q         <= 3'h0;
         waitable_q    <= 1'b0;
         addr_q        <= 24'h000000;
         req_ready     <= 1'b0;
         rsp           <= '0;
         area_select_n <= 6'h3f;
      end else begin
         rsp.done <= 1'b0;
         unique case (fsm_q)
            IDLE: begin
               req_ready <= init_q;
               if (req.valid && req_ready) begin
                  fsm_q         <= BUSY;
                  req_ready     <= 1'b0;
                  cnt_q         <= acc_len - 3'h1;
                  waitable_q    <= acc_wait;
                  addr_q        <= req.addr;
                  rsp.route     <= acc_route;
                  rsp.wide16    <= acc_wide;
                  rsp.area      <= acc_area;
                  if (acc_route == ROUTE_EXT && acc_area < 3'(NUM_CS)) begin
                     area_select_n[acc_area] <= 1'b0;
                  end
               end
            end
            BUSY: begin
               if (cnt_q == 3'h0) begin
                  fsm_q         <= IDLE;
                  rsp.done      <= 1'b1;
                  req_ready     <= 1'b1;
                  area_select_n <= 6'h3f;
               end else if (waitable_q && cnt_q == 3'h1 && bc_low_q[BCL_STALL]
                            && !stall_n_in) begin
                  cnt_q <= cnt_q;
               end else begin
                  cnt_q <= cnt_q - 3'h1;
               end
            end
         endcase
      end
   end

   // ---- pin drivers ----
   always_ff @(posedge clock or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         area_select_oe <= 6'h00;
         addr_pin_out   <= 16'h0000;
         addr_pin_oe    <= 16'h0000;
      end else begin
         area_select_oe <= cs_dir_q;
         for (int i = 0; i < NUM_UPPER; i++) begin
            addr_pin_out[i] <= ae_mask[i] ? addr_q[8+i] : port_dout[i];
            addr_pin_oe[i]  <= ae_mask[i] | adir_q[i];
         end
      end
   end
endmodule

/* ebac_pkg.sv */
package ebac_pkg;
   localparam int          ADDR_W        = 24;
   localparam int          REG_AW        = 4;
   localparam int          AREA_LSB      = 21;
   localparam int          NUM_CS        = 6;
   localparam int          NUM_UPPER     = 16;
   // register indices on the plain port
   localparam logic [3:0]  OFS_WIDTH     = 4'h0;
   localparam logic [3:0]  OFS_STATE     = 4'h1;
   localparam logic [3:0]  OFS_PW_HIGH   = 4'h2;
   localparam logic [3:0]  OFS_PW_LOW    = 4'h3;
   localparam logic [3:0]  OFS_BC_HIGH   = 4'h4;
   localparam logic [3:0]  OFS_BC_LOW    = 4'h5;
   localparam logic [3:0]  OFS_PIN_FUNC  = 4'h6;
   localparam logic [3:0]  OFS_SYS_CTRL  = 4'h7;
   localparam logic [3:0]  OFS_CS_DIR    = 4'h8;
   localparam logic [3:0]  OFS_ADIR_LO   = 4'h9;
   localparam logic [3:0]  OFS_ADIR_HI   = 4'ha;
   // field positions
   localparam int          BCL_RELEASE   = 7;
   localparam int          BCL_STALL     = 0;
   localparam int          BCH_BURST     = 5;
   localparam int          SYS_RAM_EN    = 0;
   localparam logic [7:0]  BCL_WMASK     = 8'hdf;
   // reset values
   localparam logic [7:0]  RST_STATE     = 8'hff;
   localparam logic [7:0]  RST_PW        = 8'hff;
   localparam logic [7:0]  RST_BC_HIGH   = 8'hd0;
   localparam logic [7:0]  RST_BC_LOW    = 8'h08;
   localparam logic [7:0]  RST_SYS_CTRL  = 8'h01;
   localparam logic [7:0]  RST_W_WIDE    = 8'h00;
   localparam logic [7:0]  RST_W_NARROW  = 8'hff;
   localparam logic [3:0]  RST_AE_ROMLESS = 4'hd;
   localparam logic [3:0]  RST_AE_ROM    = 4'h0;
   localparam logic [5:0]  RST_CS_ROMLESS = 6'h01;
   localparam logic [5:0]  RST_CS_ROM    = 6'h00;
   localparam logic [2:0]  MODE_WIDE     = 3'h4;
   // access lengths in states
   localparam logic [2:0]  ST_ONCHIP     = 3'h1;
   localparam logic [2:0]  ST_PERIPH     = 3'h2;
   localparam logic [2:0]  ST_SHORT      = 3'h2;
   localparam logic [2:0]  ST_LONG       = 3'h3;

   typedef enum logic [1:0] {ROUTE_ROM, ROUTE_RAM, ROUTE_IO, ROUTE_EXT} ebac_route_t;

   typedef struct packed {
      logic                valid;
      logic                write;
      logic [ADDR_W-1:0]   addr;
   } ebac_req_t;

   typedef struct packed {
      logic                done;
      ebac_route_t         route;
      logic                wide16;
      logic [2:0]          area;
   } ebac_rsp_t;
endpackage

/* ebac_ext_mem.sv */
module ebac_ext_mem (
   input  wire logic       clock,         // system clock
   input  wire logic [5:0] area_select_n, // selects from the device
   input  wire logic [2:0] hold,          // stall length in states
   output logic            stall_n_in     // wait pin, pulled up
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] age;

   always_ff @(posedge clock) begin
      if (&area_select_n)
         age <= 4'h0;
      else
         age <= age + 4'h1;
   end
   // slow part: pulls wait low for hold states, starting at the second selected state
   assign stall_n_in = !(!(&area_select_n) && age >= 4'h1 && age <= {1'b0, hold});
endmodule

/* ebac_top_assertions.sv */
module ebac_checker
   import ebac_pkg::*;
(
   input wire logic                clock,               // clock
   input wire logic                reset_n,             // reset
   input wire ebac_pkg::ebac_req_t req,                 // request
   input wire logic                req_ready,           // idle
   input wire ebac_pkg::ebac_rsp_t rsp,                 // response
   input wire logic                stall_pin_enable,    // wait gate
   input wire logic                release_request_pin, // release req
   input wire logic                release_permit,      // release on
   input wire logic                release_grant,       // granted
   input wire logic [5:0]          area_select_n        // selects
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking dcb @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   logic acc;
   assign acc = req.valid && req_ready;

   sel_onehot_a: assert property ($onehot0(~area_select_n))
      else $error("two selects low");
   sel_busy_a: assert property (!(&area_select_n) |-> !req_ready)
      else $error("select low while idle");
   grant_permit_a: assert property (release_grant |-> release_permit && $past(release_request_pin))
      else $error("grant without permit");
   onchip_one_a: assert property (rsp.done && rsp.route inside {ROUTE_RAM, ROUTE_ROM} |-> $past(acc, 2))
      else $error("on-chip access not one state");
   io_two_a: assert property (rsp.done && rsp.route == ROUTE_IO |-> $past(acc, 3))
      else $error("register access not two states");
   ext_min_a: assert property (rsp.done && rsp.route == ROUTE_EXT |-> !$past(acc, 2))
      else $error("external access under two states");
   area_number_a: assert property (acc |=> rsp.area == $past(req.addr[23:21]))
      else $error("area number wrong");
   sel_area_a: assert property (acc ##1 (rsp.route == ROUTE_EXT && rsp.area < 3'd6) |-> !area_select_n[rsp.area])
      else $error("own select not low");
   no_stall_a: assert property (acc && !stall_pin_enable |-> ##[2:7] rsp.done)
      else $error("access too long with wait pin off");

   cover property (acc && !stall_pin_enable);
   cover property (rsp.done && rsp.route == ROUTE_ROM);
   cover property (release_grant);
endmodule

bind ebac_top ebac_checker u_chk (.clock, .reset_n, .req, .req_ready, .rsp, .stall_pin_enable,
   .release_request_pin, .release_permit, .release_grant, .area_select_n);

/* ebac_top_tb.sv */
`define CHK(g, e) \
   begin \
      n_tests++; \
      if ((g) !== (e)) begin \
         n_fail++; \
         $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); \
      end \
   end

module ebac_top_tb
   import ebac_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [23:0] a;
      ebac_route_t r;
      logic [3:0]  n;
      logic        w;
   } ebac_row_t;
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic [2:0]  mode_in = 3'h4;
   logic [3:0]  reg_addr = 4'h0;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        release_request_pin = 1'b0;
   logic [15:0] port_dout = 16'ha5a5;
   ebac_req_t   req = '0;
   logic [7:0]  reg_rdata;
   logic        req_ready, stall_n_in, release_permit, release_grant, stall_pin_enable, bus16;
   ebac_rsp_t   rsp;
   logic [5:0]  area_select_n, area_select_oe;
   logic [15:0] addr_pin_out, addr_pin_oe;
   int          n_fail = 0;
   int          n_tests = 0;
   int          cyc = 0;
   // mode 4 plan: widths f0, states fd, waits 02 / 93
   ebac_row_t   rows [10] = '{
      '{24'h000100, ROUTE_EXT, 4'd6, 1'b1},
      '{24'h200000, ROUTE_EXT, 4'd2, 1'b1},
      '{24'h400000, ROUTE_EXT, 4'd4, 1'b1},
      '{24'h600000, ROUTE_EXT, 4'd5, 1'b1},
      '{24'h800000, ROUTE_EXT, 4'd5, 1'b0},
      '{24'ha00000, ROUTE_EXT, 4'd3, 1'b0},
      '{24'hc00000, ROUTE_EXT, 4'd3, 1'b0},
      '{24'he00000, ROUTE_EXT, 4'd3, 1'b0},
      '{24'hffb000, ROUTE_RAM, 4'd1, 1'b1},
      '{24'hffc000, ROUTE_IO, 4'd2, 1'b0}};

   always #10 clock = ~clock;

   ebac_top u_dut (.clock, .reset_n, .mode_in, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .req, .req_ready, .rsp, .stall_n_in, .release_request_pin, .release_permit,
      .release_grant, .stall_pin_enable, .bus16, .area_select_n, .area_select_oe,
      .port_dout, .addr_pin_out, .addr_pin_oe);
   ebac_ext_mem u_mem (.clock, .area_select_n, .hold(3'd2), .stall_n_in);

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         summarize();
      end
   end

   task automatic do_reset(input logic [2:0] m);
      reset_n <= 1'b0;
      mode_in <= m;
      repeat (16) @(posedge clock);
      reset_n <= 1'b1;
      repeat (6) @(posedge clock);
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 `CHK(reg_rdata, e)
   endtask

   // states counted from accept edge to the edge that shows done
   task automatic acc(input ebac_row_t t);
      logic [3:0] k;
      logic [5:0] s;
      k = 4'd0;
      while (req_ready !== 1'b1 && k < 4'd15) begin
         @(posedge clock);
         #1 k++;
      end
      @(posedge clock);
      req <= '{1'b1, 1'b0, t.a};
      @(posedge clock);
      req.valid <= 1'b0;
      #1 s = area_select_n;
      k = 4'd0;
      while (rsp.done !== 1'b1 && k < 4'd15) begin
         @(posedge clock);
         #1 k++;
      end
      `CHK(k, t.n)
      `CHK(s, (t.r == ROUTE_EXT && t.a[23:21] < 3'd6) ? ~(6'h01 << t.a[23:21]) : 6'h3f)
      `CHK(rsp.route, t.r)
      `CHK(rsp.area, t.a[23:21])
      if (t.r != ROUTE_IO) `CHK(rsp.wide16, t.w)
   endtask

   initial begin
      do_reset(3'h4);
      rdc(OFS_BC_LOW, 8'h08);
      rdc(OFS_PIN_FUNC, 8'h0d);
      rdc(OFS_WIDTH, 8'h00);
      rdc(OFS_STATE, 8'hff);
      rdc(OFS_SYS_CTRL, 8'h01);
      rdc(4'hc, 8'h00);
      `CHK(area_select_oe, 6'h01)
      `CHK(addr_pin_oe, 16'h1fff)
      `CHK(bus16, 1'b1)
      wr(OFS_WIDTH, 8'hf0);
      wr(OFS_STATE, 8'hfd);
      wr(OFS_PW_HIGH, 8'h02);
      wr(OFS_PW_LOW, 8'h93);
      // partner stalls every select; ignored while the gate is off
      foreach (rows[i]) acc(rows[i]);
      `CHK(addr_pin_out, 16'hbfc0)
      wr(OFS_ADIR_LO, 8'h0f);
      for (int c = 0; c < 16; c++) begin
         wr(OFS_PIN_FUNC, {4'h0, c[3:0]});
         @(posedge clock);
         #1 `CHK(addr_pin_oe, (c == 15) ? 16'hffff : (16'((1 << c) - 1) | 16'h000f))
      end
      `CHK(addr_pin_out, 16'hffc0)
      wr(OFS_BC_LOW, 8'ha9);
      release_request_pin <= 1'b1;
      rdc(OFS_BC_LOW, 8'h89);
      `CHK(release_permit, 1'b1)
      `CHK(release_grant, 1'b1)
      `CHK(stall_pin_enable, 1'b1)
      acc('{24'ha00000, ROUTE_EXT, 4'd5, 1'b0});
      wr(OFS_BC_LOW, 8'h08);
      @(posedge clock);
      #1 `CHK(release_grant, 1'b0)
      `CHK(release_permit, 1'b0)
      @(posedge clock);
      do_reset(3'h6);
      rdc(OFS_WIDTH, 8'hff);
      rdc(OFS_PIN_FUNC, 8'h00);
      `CHK(area_select_oe, 6'h00)
      `CHK(bus16, 1'b0)
      acc('{24'h000010, ROUTE_ROM, 4'd1, 1'b1});
      wr(OFS_BC_HIGH, 8'hf0);
      wr(OFS_CS_DIR, 8'h3f);
      wr(OFS_SYS_CTRL, 8'h00);
      @(posedge clock);
      #1 `CHK(bus16, 1'b1)
      `CHK(area_select_oe, 6'h3f)
      acc('{24'h100000, ROUTE_EXT, 4'd6, 1'b1});
      wr(OFS_PW_HIGH, 8'h00);
      acc('{24'hffb000, ROUTE_EXT, 4'd3, 1'b0});
      summarize();
   end
endmodule
